// ---- src/rist_pkg.sv ----
// Package for the resistance input status table: offsets, layouts, types
package rist_pkg;
    localparam int NUM_CHAN = 6;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    // Register indices (word addresses)
    localparam logic [ADDR_W-1:0] RES_BASE_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] FAULT_OPEN_ADDR = 4'h6;
    localparam logic [ADDR_W-1:0] RANGE_ADDR = 4'h7;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 4'h8;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 4'h9;
    // Field positions
    localparam int SUMMARY_LSB = 0;
    localparam int OPEN_LSB = 8;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 8;
    localparam int SIGN_BIT = 15;
    // Interrupt status bits
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_OPEN_BIT = 1;
    localparam int IRQ_RANGE_BIT = 2;
    localparam int IRQ_W = 3;
    // Reset values
    localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    // Self-test duration
    localparam int SELFTEST_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SELFTEST_CYC = (SELFTEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Per-channel sample from the scan logic
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] value;
        logic at_max;
        logic at_min;
        logic open_wire;
        logic enabled;
    } rist_sample_t;

    // Configuration and converter events per channel
    typedef struct packed {
        logic cfg_accepted;
        logic cfg_rejected;
        logic conv_started;
        logic adc_fault;
    } rist_chan_evt_t;

    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } rist_bus_req_t;
endpackage

// ---- src/rist_status_table.sv ----
// Input data table: six channel results, fault/open and range flags, interrupts
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module rist_status_table
    import rist_pkg::*;
#(
    parameter int SELFTEST_CYCLES = SELFTEST_CYC
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Scan logic
    input wire rist_sample_t [NUM_CHAN-1:0] sample_i,
    input wire rist_chan_evt_t [NUM_CHAN-1:0] evt_i,
    input wire logic selftest_pass_i,
    input wire logic selftest_fail_i,
    // Register port
    input wire rist_bus_req_t bus_i,
    output logic [DATA_W-1:0] rdata_o,
    // Indicators
    output logic config_error_o,
    output logic status_led_o,
    output logic irq_o
);

    logic [NUM_CHAN-1:0][DATA_W-1:0] result;
    logic [NUM_CHAN-1:0] not_valid;
    logic [NUM_CHAN-1:0] adc_fault;
    logic [NUM_CHAN-1:0] open_wire;
    logic [NUM_CHAN-1:0] high_limit;
    logic [NUM_CHAN-1:0] low_limit;
    logic [NUM_CHAN-1:0] summary;
    logic [NUM_CHAN-1:0] cfg_err;
    logic [DATA_W-1:0] fault_open_word;
    logic [DATA_W-1:0] range_word;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    logic [NUM_CHAN-1:0] prev_summary;
    logic [NUM_CHAN-1:0] prev_open;
    logic [NUM_CHAN-1:0] prev_range;
    logic [DATA_W-1:0] next_rdata;
    logic [$clog2(SELFTEST_CYCLES+1)-1:0] st_count;

    typedef enum logic [1:0] {RIST_ST_TEST, RIST_ST_PASS, RIST_ST_FAIL} rist_st_t;
    rist_st_t st_state;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++)
        begin : g_chan
            // Result word taken whole; sign stays in bit 15
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    result[ch] <= RESULT_RST;
                else if (sample_i[ch].valid && sample_i[ch].enabled)
                    result[ch] <= sample_i[ch].value;
            end

            // Not-valid window from accepted config to first conversion
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    not_valid[ch] <= 1'b0;
                else if (evt_i[ch].cfg_accepted)
                    not_valid[ch] <= 1'b1;
                else if (evt_i[ch].conv_started || evt_i[ch].cfg_rejected)
                    not_valid[ch] <= 1'b0;
            end

            // Rejected config posts an error; a later accepted one clears it
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    cfg_err[ch] <= 1'b0;
                else if (evt_i[ch].cfg_rejected)
                    cfg_err[ch] <= 1'b1;
                else if (evt_i[ch].cfg_accepted)
                    cfg_err[ch] <= 1'b0;
            end

            // Converter fault holds until conversion is seen again
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    adc_fault[ch] <= 1'b0;
                else if (evt_i[ch].adc_fault)
                    adc_fault[ch] <= 1'b1;
                else if (evt_i[ch].conv_started)
                    adc_fault[ch] <= 1'b0;
            end

            // Flags follow each scan result, so they clear on their own
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    open_wire[ch] <= 1'b0;
                else if (!sample_i[ch].enabled)
                    open_wire[ch] <= 1'b0;
                else if (sample_i[ch].valid)
                    open_wire[ch] <= sample_i[ch].open_wire;
            end

            // Disabled channel reports no range fault, its status is not trusted
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    high_limit[ch] <= 1'b0;
                else if (!sample_i[ch].enabled)
                    high_limit[ch] <= 1'b0;
                else if (sample_i[ch].valid)
                    high_limit[ch] <= sample_i[ch].at_max;
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    low_limit[ch] <= 1'b0;
                else if (!sample_i[ch].enabled)
                    low_limit[ch] <= 1'b0;
                else if (sample_i[ch].valid)
                    low_limit[ch] <= sample_i[ch].at_min;
            end

            assign summary[ch] = not_valid[ch] | adc_fault[ch] | open_wire[ch]
                | high_limit[ch] | low_limit[ch];
        end
    endgenerate

    // Unused positions stay zero
    always_comb
    begin
        fault_open_word = '0;
        range_word = '0;
        fault_open_word[SUMMARY_LSB +: NUM_CHAN] = summary;
        fault_open_word[OPEN_LSB +: NUM_CHAN] = open_wire;
        range_word[LOW_LSB +: NUM_CHAN] = low_limit;
        range_word[HIGH_LSB +: NUM_CHAN] = high_limit;
    end

    assign config_error_o = |cfg_err;

    // Self-test wait; saturates so a slow pass cannot wrap the count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_count <= '0;
        else if (st_state == RIST_ST_TEST
            && st_count < SELFTEST_CYCLES[$bits(st_count)-1:0])
            st_count <= st_count + 1'b1;
    end

    // Self-test sequencing for the status indicator
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_state <= RIST_ST_TEST;
        else
        begin
            unique case (st_state)
                RIST_ST_TEST:
                begin
                    if (selftest_fail_i)
                        st_state <= RIST_ST_FAIL;
                    else if (st_count >= SELFTEST_CYCLES[$bits(st_count)-1:0]
                        && selftest_pass_i)
                        st_state <= RIST_ST_PASS;
                end
                RIST_ST_PASS:
                begin
                    if (selftest_fail_i)
                        st_state <= RIST_ST_FAIL;
                end
                RIST_ST_FAIL:
                begin
                    st_state <= RIST_ST_FAIL;
                end
            endcase
        end
    end

    // Registered so the indicator never glitches on
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            status_led_o <= 1'b0;
        else
            status_led_o <= (st_state == RIST_ST_PASS) && !selftest_fail_i;
    end

    // Rising edges of any flag group raise interrupts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_summary <= '0;
            prev_open <= '0;
            prev_range <= '0;
        end
        else
        begin
            prev_summary <= summary;
            prev_open <= open_wire;
            prev_range <= high_limit | low_limit;
        end
    end

    always_comb
    begin
        irq_event = '0;
        irq_event[IRQ_FAULT_BIT] = |(summary & ~prev_summary);
        irq_event[IRQ_OPEN_BIT] = |(open_wire & ~prev_open);
        irq_event[IRQ_RANGE_BIT] = |((high_limit | low_limit) & ~prev_range);
    end

    genvar ib;
    generate
        for (ib = 0; ib < IRQ_W; ib++)
        begin : g_irq
            // Set wins over a write-one clear, so no event is lost
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    irq_status[ib] <= 1'b0;
                else if (irq_event[ib])
                    irq_status[ib] <= 1'b1;
                else if (bus_i.wr && bus_i.addr == IRQ_STATUS_ADDR && bus_i.wdata[ib])
                    irq_status[ib] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask <= IRQ_MASK_RST;
        else if (bus_i.wr && bus_i.addr == IRQ_MASK_ADDR)
            irq_mask <= bus_i.wdata[IRQ_W-1:0];
    end

    assign irq_o = |(irq_status & irq_mask);

    // Read mux; unmapped addresses return zero
    always_comb
    begin
        next_rdata = '0;
        unique case (bus_i.addr)
            FAULT_OPEN_ADDR:
            begin
                next_rdata = fault_open_word;
            end
            RANGE_ADDR:
            begin
                next_rdata = range_word;
            end
            IRQ_STATUS_ADDR:
            begin
                next_rdata[IRQ_W-1:0] = irq_status;
            end
            IRQ_MASK_ADDR:
            begin
                next_rdata[IRQ_W-1:0] = irq_mask;
            end
            default:
            begin
                // Result words below the status words; the rest read zero
                if (bus_i.addr < FAULT_OPEN_ADDR)
                    next_rdata = result[bus_i.addr[2:0]];
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_o <= '0;
        else if (bus_i.rd)
            rdata_o <= next_rdata;
        else
            rdata_o <= '0;
    end

endmodule

// ---- verification/rist_bus_master.sv ----
// Controller model driving the register port
`timescale 1ns/1ps
module rist_bus_master
    import rist_pkg::*;
(
    input wire logic clk_i,
    input wire logic [DATA_W-1:0] rdata_i,
    output rist_bus_req_t bus_o
);
    initial bus_o = '0;
    // Idle lines flip so stale address or data cannot pass as live
    task automatic idle();
        bus_o <= '{1'b0, 1'b0, ~bus_o.addr, ~bus_o.wdata};
    endtask
    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        bus_o <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        idle();
        #1;
    endtask
    task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        bus_o <= '{1'b0, 1'b1, a, bus_o.wdata};
        @(posedge clk_i);
        idle();
        #1 d = rdata_i;
    endtask
endmodule

// ---- verification/rist_checker.sv ----
// Port assertions for the status table
`timescale 1ns/1ps
module rist_checker
    import rist_pkg::*;
#(
    parameter int SELFTEST_CYCLES = 2
)
(
    // Inputs
    input wire logic clk_i,
    input wire logic rst_i,
    input wire rist_sample_t [NUM_CHAN-1:0] sample_i,
    input wire rist_chan_evt_t [NUM_CHAN-1:0] evt_i,
    input wire logic selftest_pass_i,
    input wire logic selftest_fail_i,
    input wire rist_bus_req_t bus_i,
    // Outputs
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic config_error_o,
    input wire logic status_led_o,
    input wire logic irq_o
);
    logic [15:0] up_cnt;
    logic rd6;
    logic rd7;
    rist_sample_t s0;
    assign rd6 = bus_i.rd && bus_i.addr == FAULT_OPEN_ADDR;
    assign rd7 = bus_i.rd && bus_i.addr == RANGE_ADDR;
    assign s0 = sample_i[0];
    // Saturates so a long run cannot wrap into a false early count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            up_cnt <= 16'h0000;
        else if (up_cnt != 16'hffff)
            up_cnt <= up_cnt + 16'h0001;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_idle; !$past(bus_i.rd) |-> rdata_o == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_unused; $past(bus_i.rd && bus_i.addr[3:1] == 3'h3)
        |-> rdata_o[15:14] == 2'h0 && rdata_o[7:6] == 2'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");
    property p_sum; $past(rd6) |-> (rdata_o[13:8] & ~rdata_o[5:0]) == 6'h00; endproperty
    a_sum: assert property (p_sum) else $error("open without summary");
    property p_open; s0.valid && s0.enabled && s0.open_wire ##[1:4] rd6 && !s0.valid && s0.enabled
        |=> rdata_o[8] && rdata_o[0]; endproperty
    a_open: assert property (p_open) else $error("open flag missing");
    property p_high; s0.valid && s0.enabled && s0.at_max ##[1:4] rd7 && !s0.valid && s0.enabled
        |=> rdata_o[8]; endproperty
    a_high: assert property (p_high) else $error("high flag missing");
    property p_rej; evt_i[0].cfg_rejected && !evt_i[0].cfg_accepted |=> config_error_o; endproperty
    a_rej: assert property (p_rej) else $error("config error missing");
    property p_fail; selftest_fail_i |-> ##2 (!status_led_o) [*4]; endproperty
    a_fail: assert property (p_fail) else $error("led on after failure");
    property p_wait; $rose(status_led_o) |-> up_cnt > SELFTEST_CYCLES; endproperty
    a_wait: assert property (p_wait) else $error("led on too early");
    property p_reset; disable iff (1'b0) rst_i
        |=> rdata_o == 16'h0000 && !status_led_o && !irq_o && !config_error_o; endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared");
endmodule

bind rist_status_table rist_checker #(.SELFTEST_CYCLES(SELFTEST_CYCLES)) rist_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .sample_i(sample_i), .evt_i(evt_i),
    .selftest_pass_i(selftest_pass_i), .selftest_fail_i(selftest_fail_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .config_error_o(config_error_o), .status_led_o(status_led_o),
    .irq_o(irq_o));

// ---- verification/rist_status_table_tb.sv ----
// Self-checking bench for the status table
`timescale 1ns/1ps
module rist_status_table_tb;
    import rist_pkg::*;
    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic at_max;
        logic at_min;
        logic open_wire;
    } rist_row_t;
    localparam rist_row_t ROWS [6] = '{'{16'h7fff, 1'b1, 1'b0, 1'b1}, '{16'h8000, 1'b0, 1'b1, 1'b0},
        '{16'hfff0, 1'b0, 1'b0, 1'b1}, '{16'h0123, 1'b1, 1'b0, 1'b0},
        '{16'hc000, 1'b0, 1'b1, 1'b1}, '{16'h0001, 1'b0, 1'b0, 1'b0}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    rist_sample_t [NUM_CHAN-1:0] sample = '0;
    rist_chan_evt_t [NUM_CHAN-1:0] evt = '0;
    logic pass = 1'b1;
    logic fail = 1'b0;
    rist_bus_req_t bus;
    logic [DATA_W-1:0] rdata;
    logic cfg_err;
    logic led;
    logic irq;
    logic [DATA_W-1:0] got;
    logic [DATA_W-1:0] exp6 = '0;
    logic [DATA_W-1:0] exp7 = '0;
    int failures = 0;
    int num_checks = 0;
    rist_status_table #(.SELFTEST_CYCLES(2)) rist_status_table_i (.clk_i(clk_i), .rst_i(rst_i),
        .sample_i(sample), .evt_i(evt), .selftest_pass_i(pass), .selftest_fail_i(fail),
        .bus_i(bus), .rdata_o(rdata), .config_error_o(cfg_err), .status_led_o(led), .irq_o(irq));
    rist_bus_master rist_bus_master_i (.clk_i(clk_i), .rdata_i(rdata), .bus_o(bus));
    task automatic chk_word(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_word(n, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic rd_chk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rist_bus_master_i.read(a, got);
        chk_word(n, e, got);
    endtask
    task automatic scan(input int ch, input logic en, input rist_row_t r);
        @(posedge clk_i);
        sample[ch] <= '{1'b1, r.value, r.at_max, r.at_min, r.open_wire, en};
        @(posedge clk_i);
        sample[ch].valid <= 1'b0;
    endtask
    task automatic pulse(input int ch, input rist_chan_evt_t e);
        @(posedge clk_i);
        evt[ch] <= e;
        @(posedge clk_i);
        evt[ch] <= '0;
    endtask
    task automatic print_verdict();
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        failures++;
        print_verdict();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int r = 0; r < NUM_CHAN; r++)
        begin
            scan(r, 1'b1, ROWS[r]);
            exp6[r] = ROWS[r].at_max | ROWS[r].at_min | ROWS[r].open_wire;
            exp6[r + 8] = ROWS[r].open_wire;
            exp7[r] = ROWS[r].at_min;
            exp7[r + 8] = ROWS[r].at_max;
            rd_chk("range", RANGE_ADDR, exp7);
            rd_chk("fault_open", FAULT_OPEN_ADDR, exp6);
            rd_chk("result", RES_BASE_ADDR + r[3:0], ROWS[r].value);
        end
        rd_chk("irq_status", IRQ_STATUS_ADDR, 16'h0007);
        chk_bit("irq_masked", 1'b0, irq);
        rist_bus_master_i.write(IRQ_MASK_ADDR, 16'h0007);
        chk_bit("irq_on", 1'b1, irq);
        for (int r = 0; r < 5; r++)
            scan(r, 1'b1, ROWS[5]);
        rd_chk("range_clear", RANGE_ADDR, 16'h0000);
        rd_chk("fault_clear", FAULT_OPEN_ADDR, 16'h0000);
        rist_bus_master_i.write(IRQ_STATUS_ADDR, 16'h0007);
        rd_chk("irq_cleared", IRQ_STATUS_ADDR, 16'h0000);
        chk_bit("irq_off", 1'b0, irq);
        pulse(2, 4'h8);
        rd_chk("not_valid_set", FAULT_OPEN_ADDR, 16'h0004);
        chk_bit("irq_summary", 1'b1, irq);
        pulse(2, 4'h2);
        rd_chk("not_valid_clear", FAULT_OPEN_ADDR, 16'h0000);
        pulse(0, 4'h4);
        rd_chk("rejected", FAULT_OPEN_ADDR, 16'h0000);
        chk_bit("config_error", 1'b1, cfg_err);
        pulse(4, 4'h1);
        rd_chk("adc_fault", FAULT_OPEN_ADDR, 16'h0010);
        pulse(4, 4'h2);
        scan(0, 1'b1, ROWS[2]);
        rd_chk("open_ch0", FAULT_OPEN_ADDR, 16'h0101);
        // Disabled samples drop flags but keep the stored result
        scan(0, 1'b0, ROWS[1]);
        rd_chk("disabled", FAULT_OPEN_ADDR, 16'h0000);
        rist_bus_master_i.write(RES_BASE_ADDR, 16'h5a5a);
        rd_chk("result_ro", RES_BASE_ADDR, ROWS[2].value);
        rd_chk("unmapped", 4'hf, 16'h0000);
        chk_bit("led_on", 1'b1, led);
        fail <= 1'b1;
        repeat (3) @(posedge clk_i);
        fail <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk_bit("led_latched_off", 1'b0, led);
        @(posedge clk_i);
        rst_i <= 1'b1;
        pass <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk_bit("config_error_reset", 1'b0, cfg_err);
        rd_chk("result_reset", RES_BASE_ADDR + 4'h2, RESULT_RST);
        rd_chk("fault_reset", FAULT_OPEN_ADDR, 16'h0000);
        chk_bit("led_no_pass", 1'b0, led);
        @(posedge clk_i);
        pass <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk_bit("led_after_pass", 1'b1, led);
        print_verdict();
    end
endmodule
